// ===== design/utb_defs.svh
// Register map, field positions and timing counts of the serial transceiver
`ifndef UTB_DEFS_SVH
`define UTB_DEFS_SVH
// ----------------------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------------------
`define UTB_OFF_DATA 8'h00
`define UTB_OFF_STAT 8'h04
`define UTB_OFF_CTRL 8'h08
`define UTB_OFF_BAUD 8'h0c
`define UTB_OFF_CNT 8'h10
// ----------------------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------------------
`define UTB_C_RXEN 0
`define UTB_C_TXEN 1
`define UTB_C_NINE 2
`define UTB_C_STOP2 3
`define UTB_C_BRK 4
`define UTB_C_TEIE 5
`define UTB_C_RIE 6
`define UTB_C_TX8 7
`define UTB_C_TRIG 9:8
`define UTB_C_RX8 10
`define UTB_CTRL_W 10
`define UTB_CTRL_RST 10'h000
// ----------------------------------------------------------------------------
// Status register fields
// ----------------------------------------------------------------------------
`define UTB_S_TXE 0
`define UTB_S_TXC 1
`define UTB_S_RXA 2
`define UTB_S_OVR 3
`define UTB_S_FE 4
`define UTB_S_RIDLE 5
// ----------------------------------------------------------------------------
// Timing and sizes
// ----------------------------------------------------------------------------
`define UTB_BAUD_RST 16'h0000
`define UTB_OS_LAST 4'hf
`define UTB_SMP_A 4'h7
`define UTB_SMP_B 4'h8
`define UTB_SMP_C 4'h9
`define UTB_BRK_LAST 4'hc
`define UTB_BRK_HOLD 5'h10
`define UTB_FIFO_FULL 3'h4
`define UTB_LAST_BIT8 4'h7
`define UTB_LAST_BIT9 4'h8
`define UTB_STOP_LAST1 4'h0
`define UTB_STOP_LAST2 4'h1
`endif

// ===== design/utb_pkg.sv
// Types shared by the serial transceiver
package utb_pkg;
   // -------------------------------------------------------------------------
   // State machines
   // -------------------------------------------------------------------------
   typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_BRK, TX_STOP} utb_tx_t;
   typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP, RX_BRKWAIT} utb_rx_t;
   // -------------------------------------------------------------------------
   // Whole block state
   // -------------------------------------------------------------------------
   typedef struct packed {
      logic rx_meta;
      logic rx_sync;
      logic [15:0] div_cnt;
      logic [15:0] baud_divisor;
      logic [9:0] ctl;
      logic stat_seen;
      logic [31:0] prdata;
      logic bad_addr;
      utb_tx_t tx_st;
      logic [3:0] tx_os;
      logic [3:0] tx_bit;
      logic [8:0] tx_shift_reg;
      logic tx_is_brk;
      logic [8:0] tx_hold;
      logic tx_hold_vld;
      logic tx_empty_flag;
      logic tx_complete_flag;
      logic txd;
      logic [4:0] brk_cnt;
      logic brk_armed;
      utb_rx_t rx_st;
      logic [3:0] rx_os;
      logic [3:0] rx_bit;
      logic [1:0] smp;
      logic [8:0] rx_shift_reg;
      logic rx_fe;
      logic [9:0] pend;
      logic pend_vld;
      logic [3:0][9:0] fifo;
      logic [1:0] rd_ptr;
      logic [2:0] rx_fifo_count;
      logic rx_available_flag;
      logic overrun_flag;
      logic rx_idle_flag;
   } utb_state_t;
endpackage

// ===== design/utb_top.sv
// Serial transceiver: transmit buffer and break, oversampled receiver with FIFO
`timescale 1ns/1ps
`include "utb_defs.svh"
module utb_top
   import utb_pkg::*;
(
   // Clock and reset
   input wire logic CLK_SYS,
   input wire logic SYS_RST,
   // APB slave
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [7:0] PADDR,
   input wire logic [31:0] PWDATA,
   output logic [31:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   // Serial line
   input wire logic RXD,
   output logic TXD,
   // Interrupt request
   output logic IRQ
);
   utb_state_t cur;
   utb_state_t nxt;
   // ----------------------------------------------------------------------------
   // Decodes and derived terms
   // ----------------------------------------------------------------------------
   logic setup;
   logic acc;
   logic tick16;
   logic tx_tick;
   logic rx_tick;
   logic vote;
   logic [2:0] rx_level;
   logic [9:0] head;
   logic [3:0] tx_last;
   logic [3:0] rx_last;
   logic [3:0] stop_last;
   logic data_wr;
   logic data_rd;
   logic stat_rd;
   // Setup phase captures read data; access phase performs side effects
   assign setup = PSEL & ~PENABLE;
   assign acc = PSEL & PENABLE;
   assign data_wr = acc & PWRITE & (PADDR == `UTB_OFF_DATA);
   assign data_rd = acc & ~PWRITE & (PADDR == `UTB_OFF_DATA);
   assign stat_rd = acc & ~PWRITE & (PADDR == `UTB_OFF_STAT);
   assign tick16 = (cur.div_cnt == cur.baud_divisor);
   assign tx_tick = tick16 & (cur.tx_os == `UTB_OS_LAST);
   assign rx_tick = tick16 & cur.ctl[`UTB_C_RXEN];
   assign vote = (cur.smp[0] & cur.smp[1]) | (cur.smp[0] & cur.rx_sync)
      | (cur.smp[1] & cur.rx_sync);
   assign head = cur.fifo[cur.rd_ptr];
   assign tx_last = cur.ctl[`UTB_C_NINE] ? `UTB_LAST_BIT9 : `UTB_LAST_BIT8;
   assign rx_last = cur.ctl[`UTB_C_NINE] ? `UTB_LAST_BIT9 : `UTB_LAST_BIT8;
   assign stop_last = cur.ctl[`UTB_C_STOP2] ? `UTB_STOP_LAST2 : `UTB_STOP_LAST1;
   assign rx_level = {1'b0, cur.ctl[`UTB_C_TRIG]} + 3'h1;
   // ----------------------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------------------
   always_comb begin
      logic [9:0] word;
      logic done;
      logic [1:0] wr_idx;
      word = 10'h000;
      done = 1'b0;
      wr_idx = 2'h0;
      nxt = cur;
      // Line synchroniser
      nxt.rx_meta = RXD;
      nxt.rx_sync = cur.rx_meta;
      // Sixteen-times baud divider
      nxt.div_cnt = tick16 ? 16'h0000 : cur.div_cnt + 16'h0001;
      // Register writes and read capture
      if (acc & PWRITE & (PADDR == `UTB_OFF_CTRL)) begin
         nxt.ctl = PWDATA[`UTB_CTRL_W-1:0];
      end
      if (acc & PWRITE & (PADDR == `UTB_OFF_BAUD)) begin
         nxt.baud_divisor = PWDATA[15:0];
      end
      if (setup) begin
         nxt.bad_addr = 1'b0;
         unique case (PADDR)
            `UTB_OFF_DATA: nxt.prdata = {23'h0, head[8:0]};
            `UTB_OFF_STAT: nxt.prdata = {26'h0, cur.rx_idle_flag,
               head[9] & (cur.rx_fifo_count != 3'h0), cur.overrun_flag,
               cur.rx_available_flag, cur.tx_complete_flag, cur.tx_empty_flag};
            `UTB_OFF_CTRL: nxt.prdata = {21'h0, head[8] & cur.ctl[`UTB_C_NINE],
               cur.ctl};
            `UTB_OFF_BAUD: nxt.prdata = {16'h0, cur.baud_divisor};
            `UTB_OFF_CNT: nxt.prdata = {29'h0, cur.rx_fifo_count};
            default: begin
               nxt.prdata = 32'h0;
               nxt.bad_addr = 1'b1;
            end
         endcase
      end
      // Status read arms the clearing sequence; any data access ends it
      if (stat_rd) begin
         nxt.stat_seen = 1'b1;
      end else if (data_rd | data_wr) begin
         nxt.stat_seen = 1'b0;
      end
      // Transmit bit timer
      if (tick16 && cur.tx_st != TX_IDLE) begin
         nxt.tx_os = cur.tx_os + 4'h1;
      end
      // Break request must stand for one baud period while idle
      if (!cur.ctl[`UTB_C_BRK] || cur.tx_st != TX_IDLE) begin
         nxt.brk_cnt = 5'h00;
      end else if (tick16 && cur.brk_cnt != `UTB_BRK_HOLD) begin
         nxt.brk_cnt = cur.brk_cnt + 5'h01;
      end
      if (cur.brk_cnt == `UTB_BRK_HOLD && cur.ctl[`UTB_C_BRK]) begin
         nxt.brk_armed = 1'b1;
      end
      // Transmit sequencer
      unique case (cur.tx_st)
         TX_IDLE: begin
            if (cur.tx_hold_vld) begin
               nxt.tx_shift_reg = cur.tx_hold;
               nxt.tx_hold_vld = 1'b0;
               nxt.tx_empty_flag = 1'b1;
               nxt.tx_is_brk = 1'b0;
               nxt.tx_st = TX_START;
               nxt.tx_os = 4'h0;
            end else if (cur.brk_armed) begin
               nxt.brk_armed = 1'b0;
               nxt.tx_is_brk = 1'b1;
               nxt.tx_st = TX_START;
               nxt.tx_os = 4'h0;
            end
         end
         TX_START: begin
            if (tx_tick) begin
               nxt.tx_bit = 4'h0;
               nxt.tx_st = cur.tx_is_brk ? TX_BRK : TX_DATA;
            end
         end
         TX_DATA: begin
            if (tx_tick) begin
               nxt.tx_shift_reg = {1'b0, cur.tx_shift_reg[8:1]};
               nxt.tx_bit = cur.tx_bit + 4'h1;
               if (cur.tx_bit == tx_last) begin
                  nxt.tx_bit = 4'h0;
                  nxt.tx_st = TX_STOP;
               end
            end
         end
         TX_BRK: begin
            if (tx_tick) begin
               nxt.tx_bit = cur.tx_bit + 4'h1;
               if (cur.tx_bit == `UTB_BRK_LAST) begin
                  nxt.tx_bit = 4'h0;
                  nxt.tx_st = TX_STOP;
               end
            end
         end
         TX_STOP: begin
            if (tx_tick) begin
               nxt.tx_bit = cur.tx_bit + 4'h1;
               if (cur.tx_bit == `UTB_STOP_LAST2) begin
                  nxt.tx_complete_flag = 1'b1;
                  nxt.tx_st = TX_IDLE;
                  if (cur.tx_is_brk && cur.ctl[`UTB_C_BRK] && !cur.tx_hold_vld) begin
                     nxt.brk_armed = 1'b1;
                  end
               end
            end
         end
         default: nxt.tx_st = TX_IDLE;
      endcase
      // Data write, accepted only after a status read and while a slot is free
      if (data_wr && cur.stat_seen && cur.tx_empty_flag && cur.ctl[`UTB_C_TXEN]) begin
         nxt.tx_complete_flag = nxt.tx_st == TX_IDLE && cur.tx_st == TX_STOP;
         if (cur.tx_st == TX_IDLE && !cur.tx_hold_vld) begin
            nxt.tx_shift_reg = {cur.ctl[`UTB_C_TX8], PWDATA[7:0]};
            nxt.tx_is_brk = 1'b0;
            nxt.tx_st = TX_START;
            nxt.tx_os = 4'h0;
            nxt.tx_empty_flag = 1'b1;
         end else begin
            nxt.tx_hold = {cur.ctl[`UTB_C_TX8], PWDATA[7:0]};
            nxt.tx_hold_vld = 1'b1;
            nxt.tx_empty_flag = 1'b0;
         end
      end
      // Transmitter disabled: stop at once and return to the empty state
      if (!cur.ctl[`UTB_C_TXEN]) begin
         nxt.tx_st = TX_IDLE;
         nxt.tx_hold_vld = 1'b0;
         nxt.tx_empty_flag = 1'b1;
         nxt.tx_complete_flag = 1'b1;
         nxt.brk_armed = 1'b0;
      end
      // Line level follows the state that is entered
      nxt.txd = !(nxt.tx_st == TX_START || nxt.tx_st == TX_BRK
         || (nxt.tx_st == TX_DATA && !nxt.tx_shift_reg[0]));
      // Receive sampler
      if (rx_tick) begin
         unique case (cur.rx_st)
            RX_IDLE: begin
               if (!cur.rx_sync) begin
                  nxt.rx_st = RX_START;
                  nxt.rx_os = 4'h0;
                  nxt.rx_fe = 1'b0;
                  nxt.rx_idle_flag = 1'b0;
               end
            end
            RX_BRKWAIT: begin
               if (cur.rx_sync) begin
                  nxt.rx_st = RX_IDLE;
               end
            end
            default: begin
               nxt.rx_os = cur.rx_os + 4'h1;
               if (cur.rx_os == `UTB_SMP_A) begin
                  nxt.smp[0] = cur.rx_sync;
               end
               if (cur.rx_os == `UTB_SMP_B) begin
                  nxt.smp[1] = cur.rx_sync;
               end
               if (cur.rx_os == `UTB_SMP_C) begin
                  if (cur.rx_st == RX_START && vote) begin
                     nxt.rx_st = RX_IDLE;
                     nxt.rx_idle_flag = 1'b1;
                  end
                  if (cur.rx_st == RX_DATA) begin
                     nxt.rx_shift_reg = cur.ctl[`UTB_C_NINE]
                        ? {vote, cur.rx_shift_reg[8:1]}
                        : {1'b0, vote, cur.rx_shift_reg[7:1]};
                  end
                  if (cur.rx_st == RX_STOP) begin
                     nxt.rx_fe = cur.rx_fe | ~vote;
                     if (cur.rx_bit == stop_last) begin
                        done = 1'b1;
                        word = {cur.rx_fe | ~vote, cur.rx_shift_reg};
                        nxt.rx_idle_flag = 1'b1;
                        nxt.rx_st = (!vote && cur.rx_shift_reg == 9'h000)
                           ? RX_BRKWAIT : RX_IDLE;
                     end
                  end
               end
               if (cur.rx_os == `UTB_OS_LAST) begin
                  nxt.rx_bit = cur.rx_bit + 4'h1;
                  if (cur.rx_st == RX_START) begin
                     nxt.rx_bit = 4'h0;
                     nxt.rx_st = RX_DATA;
                  end
                  if (cur.rx_st == RX_DATA && cur.rx_bit == rx_last) begin
                     nxt.rx_bit = 4'h0;
                     nxt.rx_st = RX_STOP;
                  end
               end
            end
         endcase
      end
      // FIFO read pops the head; the held fifth word then moves in
      if (data_rd && cur.rx_fifo_count != 3'h0) begin
         nxt.rd_ptr = cur.rd_ptr + 2'h1;
         nxt.rx_fifo_count = cur.rx_fifo_count - 3'h1;
      end
      if (data_rd && cur.stat_seen) begin
         nxt.rx_available_flag = 1'b0;
         nxt.overrun_flag = 1'b0;
      end
      if (nxt.pend_vld && nxt.rx_fifo_count != `UTB_FIFO_FULL) begin
         wr_idx = nxt.rd_ptr + nxt.rx_fifo_count[1:0];
         nxt.fifo[wr_idx] = nxt.pend;
         nxt.rx_fifo_count = nxt.rx_fifo_count + 3'h1;
         nxt.pend_vld = 1'b0;
      end
      // Completed word enters the FIFO, or is held as the fifth word
      if (done) begin
         if (nxt.rx_fifo_count != `UTB_FIFO_FULL) begin
            wr_idx = nxt.rd_ptr + nxt.rx_fifo_count[1:0];
            nxt.fifo[wr_idx] = word;
            nxt.rx_fifo_count = nxt.rx_fifo_count + 3'h1;
         end else begin
            nxt.pend = word;
            nxt.pend_vld = 1'b1;
            nxt.overrun_flag = 1'b1;
         end
      end
      if (nxt.rx_fifo_count != 3'h0) begin
         nxt.rx_available_flag = 1'b1;
      end
      // Receiver disabled: park the sampler and drop the held word
      if (!cur.ctl[`UTB_C_RXEN]) begin
         nxt.rx_st = RX_IDLE;
         nxt.rx_idle_flag = 1'b1;
         nxt.pend_vld = 1'b0;
      end
   end
   // ----------------------------------------------------------------------------
   // State register
   // ----------------------------------------------------------------------------
   always_ff @(posedge CLK_SYS) begin
      if (SYS_RST) begin
         cur <= '0;
         cur.rx_meta <= 1'b1;
         cur.rx_sync <= 1'b1;
         cur.baud_divisor <= `UTB_BAUD_RST;
         cur.ctl <= `UTB_CTRL_RST;
         cur.tx_st <= TX_IDLE;
         cur.rx_st <= RX_IDLE;
         cur.tx_empty_flag <= 1'b1;
         cur.tx_complete_flag <= 1'b1;
         cur.txd <= 1'b1;
         cur.rx_idle_flag <= 1'b1;
      end else begin
         cur <= nxt;
      end
   end
   // ----------------------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------------------
   assign PRDATA = cur.prdata;
   assign PREADY = 1'b1;
   assign PSLVERR = acc & cur.bad_addr;
   assign TXD = cur.txd;
   // Break frames leave the empty flag alone, so they never request
   assign IRQ = (cur.tx_empty_flag & cur.ctl[`UTB_C_TEIE])
      | (cur.ctl[`UTB_C_RIE] & ((cur.rx_fifo_count >= rx_level)
      | cur.overrun_flag));
   // ----------------------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------------------
   default clocking cb @(posedge CLK_SYS); endclocking
   default disable iff (SYS_RST);
   a_idle_write_start: assert property (data_wr && cur.stat_seen && cur.tx_empty_flag
      && cur.ctl[`UTB_C_TXEN] && cur.tx_st == TX_IDLE && !cur.tx_hold_vld
      |=> cur.tx_st == TX_START && cur.tx_empty_flag && !TXD)
      else $error("idle write did not start a frame");
   a_busy_write_hold: assert property (data_wr && cur.stat_seen && cur.tx_empty_flag
      && cur.ctl[`UTB_C_TXEN] && cur.tx_st != TX_IDLE
      |=> cur.tx_hold_vld && !cur.tx_empty_flag)
      else $error("busy write not held");
   a_flag_clear_seq: assert property ($fell(cur.tx_complete_flag) && cur.ctl[`UTB_C_TXEN]
      |-> $past(data_wr) && $past(cur.stat_seen))
      else $error("complete flag cleared without sequence");
   a_tx_empty_irq: assert property (cur.tx_empty_flag && cur.ctl[`UTB_C_TEIE] |-> IRQ)
      else $error("empty flag without interrupt");
   a_two_stop_bits: assert property (cur.tx_st == TX_STOP |-> TXD)
      else $error("stop bit not high");
   a_stop_to_idle: assert property (cur.tx_st == TX_STOP && tx_tick
      && cur.tx_bit == `UTB_STOP_LAST2 && cur.ctl[`UTB_C_TXEN] |=> cur.tx_complete_flag
      && cur.tx_st == TX_IDLE) else $error("frame end did not set complete flag");
   a_brk_no_irq: assert property (cur.tx_st == TX_BRK && !cur.tx_hold_vld
      |-> cur.tx_empty_flag == $past(cur.tx_empty_flag))
      else $error("break changed empty flag");
   a_fifo_bound: assert property (cur.rx_fifo_count <= `UTB_FIFO_FULL)
      else $error("fifo count above depth");
   a_overrun_set: assert property (rx_tick && cur.rx_st == RX_STOP
      && cur.rx_os == `UTB_SMP_C && cur.rx_bit == stop_last
      && cur.rx_fifo_count == `UTB_FIFO_FULL && !data_rd && !cur.pend_vld
      && cur.ctl[`UTB_C_RXEN] |=> cur.overrun_flag && cur.rx_fifo_count == `UTB_FIFO_FULL)
      else $error("overrun not flagged");
   a_ridle_start: assert property (rx_tick && cur.rx_st == RX_IDLE && !cur.rx_sync
      |=> !cur.rx_idle_flag ##0 cur.rx_st == RX_START)
      else $error("idle flag not cleared at start");
   a_avail_tracks: assert property (cur.rx_fifo_count != 3'h0 |-> cur.rx_available_flag)
      else $error("data present without available flag");
   a_break_wait: assert property (cur.rx_st == RX_BRKWAIT && !cur.rx_sync
      && cur.ctl[`UTB_C_RXEN] |=> cur.rx_st == RX_BRKWAIT)
      else $error("low line left break wait");
   c_tx_frame: cover property (cur.tx_st == TX_STOP ##1 cur.tx_st == TX_IDLE);
   c_break_sent: cover property (cur.tx_st == TX_BRK);
   c_overrun: cover property ($rose(cur.overrun_flag));
   c_rx_break: cover property (cur.rx_st == RX_BRKWAIT);
endmodule

// ===== sim/utb_line_model.sv
// Remote serial device: drives frames onto the receive line and decodes the transmit line
`timescale 1ns/1ps
module utb_line_model #(
   parameter int BITC = 32
) (
   // Clock
   input wire logic clk,
   // Serial line
   input wire logic txd,
   output logic rxd,
   // Decoded frame: stop level in bit 8
   output logic [8:0] got,
   output logic got_vld
);
   logic [8:0] f;
   // Line idles high between frames
   initial begin
      rxd = 1'b1;
      got = 9'h000;
      got_vld = 1'b0;
   end
   // One frame: start, data LSB first, two stop bits at the given level
   task automatic send(input logic [8:0] d, input int nb, input logic stp);
      rxd <= 1'b0;
      repeat (BITC) @(posedge clk);
      for (int k = 0; k < nb; k++) begin
         rxd <= d[k];
         repeat (BITC) @(posedge clk);
      end
      rxd <= stp;
      repeat (2 * BITC) @(posedge clk);
      rxd <= 1'b1;
      @(posedge clk);
   endtask
   // Mid-bit decode; both stop bits must be high for bit 8 to read one
   always begin
      @(negedge txd);
      repeat (BITC / 2) @(posedge clk);
      for (int i = 0; i < 8; i++) begin
         repeat (BITC) @(posedge clk);
         f[i] = txd;
      end
      repeat (BITC) @(posedge clk);
      f[8] = txd;
      repeat (BITC) @(posedge clk);
      got <= {f[8] & txd, f[7:0]};
      got_vld <= 1'b1;
      @(posedge clk);
      got_vld <= 1'b0;
      wait (txd === 1'b1);
   end
endmodule

// ===== sim/tb_utb_top.sv
// Self-checking bench for the serial transceiver
`timescale 1ns/1ps
`include "utb_defs.svh"
module tb_utb_top;
   localparam int BITC = 32;
   logic CLK_SYS, SYS_RST, PSEL, PENABLE, PWRITE, PREADY, PSLVERR, RXD, TXD, IRQ;
   logic [7:0] PADDR;
   logic [31:0] PWDATA, PRDATA, r;
   logic [8:0] got;
   logic got_vld;
   logic [7:0] b;
   logic [7:0] rb[6];
   logic [8:0] txq[$];
   logic [65:0] rdq[$];
   logic [65:0] e;
   int fail_count = 0;
   int total_checks = 0;
   utb_top i_dut (.CLK_SYS(CLK_SYS), .SYS_RST(SYS_RST), .PSEL(PSEL), .PENABLE(PENABLE),
      .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
      .PSLVERR(PSLVERR), .RXD(RXD), .TXD(TXD), .IRQ(IRQ));
   utb_line_model #(.BITC(BITC)) i_line (.clk(CLK_SYS), .txd(TXD), .rxd(RXD), .got(got),
      .got_vld(got_vld));
   // 200 MHz clock
   initial begin
      CLK_SYS = 1'b0;
      forever #2.5 CLK_SYS = ~CLK_SYS;
   end
   task automatic chk(input logic ok, input string m);
      total_checks++;
      if (!ok) begin
         fail_count++;
         $display("MISMATCH at %0t: %s", $time, m);
      end
   endtask
   // APB transfer; a read notes its expected {slverr, data} under a mask
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
      input logic [32:0] ex, input logic [32:0] mk);
      if (!w) rdq.push_back({ex, mk});
      PSEL <= 1'b1;
      PENABLE <= 1'b0;
      PWRITE <= w;
      PADDR <= a;
      PWDATA <= d;
      @(posedge CLK_SYS);
      PENABLE <= 1'b1;
      do @(posedge CLK_SYS); while (PREADY !== 1'b1);
      r = PRDATA;
      PSEL <= 1'b0;
      PENABLE <= 1'b0;
      @(posedge CLK_SYS);
   endtask
   // Watcher: compares read data and decoded frames with the oldest notes
   always @(posedge CLK_SYS) begin
      if (PSEL && PENABLE && PREADY === 1'b1 && !PWRITE) begin
         e = rdq.pop_front();
         if (e[32:0] != 33'h0) chk((({PSLVERR, PRDATA} & e[32:0]) === e[65:33]), "read");
      end
      if (got_vld === 1'b1) chk(got === txq.pop_front(), "tx frame");
   end
   task automatic print_verdict;
      $display("checks %0d mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   initial begin
      repeat (60000) @(posedge CLK_SYS);
      fail_count++;
      print_verdict();
   end
   initial begin
      {SYS_RST, PSEL, PENABLE, PWRITE, PADDR, PWDATA} = {3'b100, 41'h0};
      void'($urandom(32'hef61));
      repeat (10) @(posedge CLK_SYS);
      SYS_RST <= 1'b0;
      @(posedge CLK_SYS);
      // Reset values and an unmapped address
      bus(0, `UTB_OFF_STAT, 0, 33'h23, 33'h3f);
      bus(0, `UTB_OFF_CTRL, 0, 33'h0, 33'h7ff);
      bus(0, `UTB_OFF_CNT, 0, 33'h0, 33'h7);
      bus(0, 8'h14, 0, 33'h100000000, 33'h1ffffffff);
      bus(1, `UTB_OFF_BAUD, 32'h1, 0, 0);
      bus(1, `UTB_OFF_CTRL, 32'hb, 0, 0);
      $display("reset test done");
      // Transmit: idle load, held byte, flag clearing
      for (int n = 0; n < 4; n++) begin
         b = 8'($urandom);
         r = 32'h0;
         while (r[0] !== 1'b1) bus(0, `UTB_OFF_STAT, 0, 0, 0);
         bus(1, `UTB_OFF_DATA, {24'h0, b}, 0, 0);
         txq.push_back({1'b1, b});
         bus(0, `UTB_OFF_STAT, 0, {32'h0, n == 0}, 33'h3);
      end
      wait (txq.size() == 0);
      repeat (2 * BITC) @(posedge CLK_SYS);
      bus(0, `UTB_OFF_STAT, 0, 33'h3, 33'h3);
      // Break character, then break bit cleared
      txq.push_back(9'h000);
      bus(1, `UTB_OFF_CTRL, 32'h1b, 0, 0);
      repeat (3 * BITC) @(posedge CLK_SYS);
      bus(1, `UTB_OFF_CTRL, 32'hb, 0, 0);
      wait (txq.size() == 0);
      repeat (3 * BITC) @(posedge CLK_SYS);
      bus(0, `UTB_OFF_STAT, 0, 33'h3, 33'h3);
      bus(1, `UTB_OFF_CTRL, 32'h2b, 0, 0);
      chk(IRQ === 1'b1, "empty flag irq");
      bus(1, `UTB_OFF_CTRL, 32'h34b, 0, 0);
      chk(IRQ === 1'b0, "irq below trigger");
      $display("transmit test done");
      // Receive: FIFO fill, held fifth word, overrun, clearing
      for (int k = 0; k < 6; k++) begin
         rb[k] = 8'($urandom);
         i_line.send({1'b0, rb[k]}, 8, 1'b1);
         if (k == 4) bus(0, `UTB_OFF_CNT, 0, 33'h4, 33'h7);
         if (k == 3) bus(0, `UTB_OFF_STAT, 0, 33'h4, 33'hc);
         if (k == 3) chk(IRQ === 1'b1, "trigger irq");
      end
      bus(0, `UTB_OFF_STAT, 0, 33'hc, 33'hc);
      for (int k = 0; k < 5; k++) begin
         bus(0, `UTB_OFF_STAT, 0, 0, 0);
         bus(0, `UTB_OFF_DATA, 0, {25'h0, rb[k == 4 ? 5 : k]}, 33'h1ff);
      end
      bus(0, `UTB_OFF_STAT, 0, 33'h0, 33'hc);
      $display("receive test done");
      // Received break, then a normal word
      i_line.send(9'h000, 8, 1'b0);
      repeat (2 * BITC) @(posedge CLK_SYS);
      bus(0, `UTB_OFF_CNT, 0, 33'h1, 33'h7);
      bus(0, `UTB_OFF_STAT, 0, 33'h34, 33'h34);
      bus(0, `UTB_OFF_DATA, 0, 33'h0, 33'h1ff);
      b = 8'($urandom);
      i_line.send({1'b0, b}, 8, 1'b1);
      bus(0, `UTB_OFF_STAT, 0, 33'h24, 33'h34);
      bus(0, `UTB_OFF_DATA, 0, {25'h0, b}, 33'h1ff);
      // Nine-bit word: top bit shows in the control register
      bus(1, `UTB_OFF_CTRL, 32'h34f, 0, 0);
      i_line.send({1'b1, b}, 9, 1'b1);
      bus(0, `UTB_OFF_CTRL, 0, 33'h400, 33'h400);
      bus(0, `UTB_OFF_STAT, 0, 0, 0);
      bus(0, `UTB_OFF_DATA, 0, {24'h0, 1'b1, b}, 33'h1ff);
      $display("break receive test done");
      print_verdict();
   end
endmodule
